// ---- adc_output_trim_pll_regs.sv ----
/*
 adc_output_trim_pll_regs: AHB-Lite register bank for global offset trim,
 word-clock and extra-LSB pair control, synthesizer calibration, output
 clock delay and first user pattern; applies them to one sample stream.
 assumes: single-word AHB-Lite transfers, one channel sample per cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_output_trim_pll_regs (
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic      [31:0]               hrdata,
	output logic                           hreadyout,
	output logic      [1:0]                hresp,
	input  wire logic signed [20:0]        sampleIn,
	input  wire adc_trim_pkg::res_mode_type resMode,
	input  wire logic                      decimationOn,
	input  wire logic                      pllSelected,
	input  wire logic                      pllEnabled,
	input  wire logic                      lvdsMode,
	input  wire logic                      wordClock,
	input  wire logic                      overRange,
	output logic      [17:0]               dataOut,
	output logic      [1:0]                extraLsbOut,
	output logic      [1:0]                wckOvrOut,
	output logic                           wckOvrOutEn,
	output logic      [15:0]               patternOut,
	output logic                           pllClkToCore,
	output logic      [3:0]                outclkVcoDelay,
	output logic                           calStart
);

	localparam int W = adc_trim_pkg::DATA_W + adc_trim_pkg::FRAC_W;

	logic [7:0]  offsetLow_ff;
	logic [7:0]  offsetHigh_ff;
	logic [7:0]  wckLsbCtrl_ff;
	logic [7:0]  synthCal_ff;
	logic [7:0]  synthPhase_ff;
	logic [7:0]  patternLow_ff;
	logic [7:0]  patternHigh_ff;
	logic        wrPending_ff;
	logic [7:0]  wrIndex_ff;
	logic [7:0]  nxt_rdata;
	logic [31:0] rdata_ff;
	logic        calStart_ff;
	logic        calBusy;
	logic        calDone;
	logic [17:0] dataOut_ff;
	logic [1:0]  extraLsb_ff;
	logic [1:0]  wckOvr_ff;
	logic [15:0] pattern_ff;
	logic [3:0]  delay_ff;
	logic        pllClk_ff;
	logic signed [W-1:0] trimmed;
	logic        addrPhase;
	logic        extraLsbOn;
	logic        pllActive;
	logic [7:0]  calStatus;
	logic [15:0] offsetWord;
	logic [15:0] patternRaw;

	// register index from a word byte address
	function automatic logic [7:0] reg_index(input logic [31:0] addr);
		reg_index = addr[9:2];
	endfunction

	// printed delay codes: 110 and 111 jump to 14 and 15
	function automatic logic [3:0] vco_cycles(input logic [2:0] code);
		if (code == adc_trim_pkg::DLY_CODE_15) begin
			vco_cycles = adc_trim_pkg::DLY_CYC_15;
		end else if (code == adc_trim_pkg::DLY_CODE_14) begin
			vco_cycles = adc_trim_pkg::DLY_CYC_14;
		end else begin
			vco_cycles = {1'b0, code};
		end
	endfunction

	// low bits a mode leaves unused in the 16-bit pattern
	function automatic logic [15:0] pattern_mask(input adc_trim_pkg::res_mode_type m);
		unique case (m)
			adc_trim_pkg::RES_12: pattern_mask = 16'hFFF0;
			adc_trim_pkg::RES_14: pattern_mask = 16'hFFFC;
			adc_trim_pkg::RES_16: pattern_mask = 16'hFFFF;
			adc_trim_pkg::RES_18: pattern_mask = 16'hFFFF;
		endcase
	endfunction : pattern_mask

	// write strobe of one register, in the data phase of its transfer
	function automatic logic wr_hit(input logic [7:0] target);
		wr_hit = wrPending_ff && wrIndex_ff == target;
	endfunction : wr_hit

	// IDLE and BUSY carry no transfer
	function automatic logic is_transfer(input logic [1:0] trans);
		is_transfer = trans == adc_trim_pkg::HTRANS_NONSEQ ||
			trans == adc_trim_pkg::HTRANS_SEQ;
	endfunction : is_transfer

	// a set polarity bit inverts both wires of a pair
	function automatic logic [1:0] invert_pair(input logic [1:0] pair, input logic pol);
		invert_pair = pair ^ {2{pol}};
	endfunction : invert_pair

	assign addrPhase = hsel && hready && is_transfer(htrans);

	// zero-wait slave: data phase always completes in one cycle
	assign hreadyout = 1'b1;
	assign hresp     = adc_trim_pkg::HRESP_OKAY;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wrPending_ff <= 1'b0;
		end else begin
			wrPending_ff <= addrPhase && hwrite;
		end
	end

	// index is read only under the pending flag; reset keeps it known anyway
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wrIndex_ff <= '0;
		end else begin
			wrIndex_ff <= reg_index(haddr);
		end
	end

	// busy in bit 1, done in bit 0; done stays set until the next start
	assign calStatus = {6'h00, calBusy, calDone};

	always_comb begin
		unique case (reg_index(haddr))
			adc_trim_pkg::IDX_OFFSET_LOW:   nxt_rdata = offsetLow_ff;
			adc_trim_pkg::IDX_OFFSET_HIGH:  nxt_rdata = offsetHigh_ff;
			adc_trim_pkg::IDX_WCK_LSB_CTRL: nxt_rdata = wckLsbCtrl_ff;
			adc_trim_pkg::IDX_SYNTH_CAL:    nxt_rdata = synthCal_ff;
			adc_trim_pkg::IDX_SYNTH_PHASE:  nxt_rdata = synthPhase_ff;
			adc_trim_pkg::IDX_PATTERN_LOW:  nxt_rdata = patternLow_ff;
			adc_trim_pkg::IDX_PATTERN_HIGH: nxt_rdata = patternHigh_ff;
			adc_trim_pkg::IDX_CAL_STATUS:   nxt_rdata = calStatus;
			default:                        nxt_rdata = 8'h00;
		endcase
	end

	// unmapped reads return zero, unmapped writes are dropped
	// captured in the address phase, so hrdata stands through the data phase
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else if (addrPhase && !hwrite) begin
			rdata_ff <= {24'h000000, nxt_rdata};
		end
	end
	assign hrdata = rdata_ff;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			offsetLow_ff <= adc_trim_pkg::RST_OFFSET;
		end else if (wr_hit(adc_trim_pkg::IDX_OFFSET_LOW)) begin
			offsetLow_ff <= hwdata[7:0];
		end
	end

	// bytes load apart: a mixed offset shows between the two writes
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			offsetHigh_ff <= adc_trim_pkg::RST_OFFSET;
		end else if (wr_hit(adc_trim_pkg::IDX_OFFSET_HIGH)) begin
			offsetHigh_ff <= hwdata[7:0];
		end
	end
	assign offsetWord = {offsetHigh_ff, offsetLow_ff};

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wckLsbCtrl_ff <= adc_trim_pkg::RST_WCK_LSB_CTRL;
		end else if (wr_hit(adc_trim_pkg::IDX_WCK_LSB_CTRL)) begin
			wckLsbCtrl_ff <= hwdata[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			synthCal_ff <= adc_trim_pkg::RST_SYNTH_CAL;
		end else if (wr_hit(adc_trim_pkg::IDX_SYNTH_CAL)) begin
			synthCal_ff <= hwdata[7:0];
		end
	end

	// start only on a real transition of the toggle bit
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			calStart_ff <= 1'b0;
		end else if (wr_hit(adc_trim_pkg::IDX_SYNTH_CAL)) begin
			calStart_ff <= hwdata[adc_trim_pkg::BIT_CAL_TOGGLE] !=
				synthCal_ff[adc_trim_pkg::BIT_CAL_TOGGLE];
		end else begin
			calStart_ff <= 1'b0;
		end
	end
	assign calStart = calStart_ff;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			synthPhase_ff <= adc_trim_pkg::RST_SYNTH_PHASE;
		end else if (wr_hit(adc_trim_pkg::IDX_SYNTH_PHASE)) begin
			synthPhase_ff <= hwdata[7:0] & adc_trim_pkg::PHASE_MASK;
		end
	end

	// low bits are stored as written; masking happens on use
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			patternLow_ff <= adc_trim_pkg::RST_PATTERN;
		end else if (wr_hit(adc_trim_pkg::IDX_PATTERN_LOW)) begin
			patternLow_ff <= hwdata[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			patternHigh_ff <= adc_trim_pkg::RST_PATTERN;
		end else if (wr_hit(adc_trim_pkg::IDX_PATTERN_HIGH)) begin
			patternHigh_ff <= hwdata[7:0];
		end
	end
	assign patternRaw = {patternHigh_ff, patternLow_ff};

	synth_cal_timer calTimer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.start   (calStart_ff),
		.busy    (calBusy),
		.done    (calDone)
	);

	offset_trim_path trimPath (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.sample_in  (sampleIn),
		.offset     (offsetWord),
		.mode       (resMode),
		.sample_out (trimmed)
	);

	assign extraLsbOn = wckLsbCtrl_ff[adc_trim_pkg::BIT_LSB_EN] && decimationOn;

	// extra pair only exists with decimation; otherwise the word stays at 16 bits
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dataOut_ff <= '0;
		end else if (extraLsbOn) begin
			dataOut_ff <= trimmed[W-1:adc_trim_pkg::FRAC_W];
		end else begin
			dataOut_ff <= {trimmed[W-1:adc_trim_pkg::FRAC_W+2], 2'b00};
		end
	end

	// polarity only matters on the differential pins
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			extraLsb_ff <= '0;
		end else if (extraLsbOn) begin
			extraLsb_ff <= invert_pair(trimmed[adc_trim_pkg::FRAC_W+1:adc_trim_pkg::FRAC_W],
				lvdsMode && wckLsbCtrl_ff[adc_trim_pkg::BIT_LSB_POL]);
		end else begin
			extraLsb_ff <= '0;
		end
	end

	// a disabled pair is held low rather than left at its last value
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wckOvr_ff <= '0;
		end else if (wckLsbCtrl_ff[adc_trim_pkg::BIT_WCK_EN]) begin
			wckOvr_ff <= invert_pair({wordClock, overRange},
				wckLsbCtrl_ff[adc_trim_pkg::BIT_WCK_POL]);
		end else begin
			wckOvr_ff <= '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pattern_ff <= '0;
		end else begin
			pattern_ff <= patternRaw & pattern_mask(resMode);
		end
	end

	assign pllActive = pllSelected && pllEnabled;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pllClk_ff <= 1'b0;
		end else begin
			pllClk_ff <= pllActive && synthPhase_ff[adc_trim_pkg::BIT_PLL_CLK_EN];
		end
	end

	// decimation retimes the output clock, so the delay is dropped there
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			delay_ff <= '0;
		end else if (pllActive && !decimationOn) begin
			delay_ff <= vco_cycles(
				synthPhase_ff[adc_trim_pkg::DLY_MSB:adc_trim_pkg::DLY_LSB]);
		end else begin
			delay_ff <= '0;
		end
	end

	assign dataOut        = dataOut_ff;
	assign extraLsbOut    = extraLsb_ff;
	assign wckOvrOut      = wckOvr_ff;
	assign wckOvrOutEn    = wckLsbCtrl_ff[adc_trim_pkg::BIT_WCK_EN];
	assign patternOut     = pattern_ff;
	assign pllClkToCore   = pllClk_ff;
	assign outclkVcoDelay = delay_ff;

endmodule : adc_output_trim_pll_regs
`default_nettype wire

// ---- adc_trim_pkg.sv ----
/*
 adc_trim_pkg: register map, reset values, field positions and modes of the
 output trim and synthesizer register bank.
 assumes: used as adc_trim_pkg::name, never imported.
*/
package adc_trim_pkg;

	// register indices as printed; byte address is four times the index
	localparam logic [7:0]  IDX_OFFSET_LOW   = 8'h66;
	localparam logic [7:0]  IDX_OFFSET_HIGH  = 8'h67;
	localparam logic [7:0]  IDX_WCK_LSB_CTRL = 8'h68;
	localparam logic [7:0]  IDX_SYNTH_CAL    = 8'h6B;
	localparam logic [7:0]  IDX_SYNTH_PHASE  = 8'h6D;
	localparam logic [7:0]  IDX_PATTERN_LOW  = 8'h74;
	localparam logic [7:0]  IDX_PATTERN_HIGH = 8'h75;
	localparam logic [7:0]  IDX_CAL_STATUS   = 8'hD1;

	// reset values
	localparam logic [7:0]  RST_OFFSET       = 8'h00;
	localparam logic [7:0]  RST_WCK_LSB_CTRL = 8'h24;
	localparam logic [7:0]  RST_SYNTH_CAL    = 8'h08;
	localparam logic [7:0]  RST_SYNTH_PHASE  = 8'h00;
	localparam logic [7:0]  RST_PATTERN      = 8'h00;

	// field positions
	localparam int          BIT_WCK_POL      = 3;
	localparam int          BIT_WCK_EN       = 2;
	localparam int          BIT_LSB_EN       = 1;
	localparam int          BIT_LSB_POL      = 0;
	localparam int          BIT_CAL_TOGGLE   = 2;
	localparam int          BIT_PLL_CLK_EN   = 5;
	localparam int          DLY_LSB          = 1;
	localparam int          DLY_MSB          = 3;
	localparam logic [7:0]  PHASE_MASK       = 8'h3F;

	// calibration timing: 10 MHz clock, 10 us calibration
	localparam int          CLK_HZ           = 10_000_000;
	localparam int          CAL_TIME_US      = 10;
	localparam int          CAL_CYCLES       = (CAL_TIME_US * CLK_HZ) / 1_000_000;
	localparam int          CAL_CNT_W        = 8;

	// delay code 110 and 111 map to 14 and 15; others to the code itself
	localparam logic [2:0]  DLY_CODE_14      = 3'h6;
	localparam logic [2:0]  DLY_CODE_15      = 3'h7;
	localparam logic [3:0]  DLY_CYC_14       = 4'hE;
	localparam logic [3:0]  DLY_CYC_15       = 4'hF;

	// output resolution modes
	typedef enum logic [1:0] {
		RES_12 = 2'h0,
		RES_14 = 2'h1,
		RES_16 = 2'h2,
		RES_18 = 2'h3
	} res_mode_type;

	localparam int          DATA_W           = 18;
	localparam int          FRAC_W           = 3;

	// AHB-Lite codes
	localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ       = 2'h3;
	localparam logic [1:0]  HRESP_OKAY       = 2'h0;

endpackage : adc_trim_pkg

// ---- synth_cal_timer.sv ----
/*
 synth_cal_timer: runs one synthesizer calibration per start pulse and
 reports busy and done.
 assumes: start is a one-cycle pulse on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module synth_cal_timer (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	output logic             busy,
	output logic             done
);

	typedef enum logic [1:0] {
		CAL_IDLE = 2'b01,
		CAL_RUN  = 2'b10
	} cal_state_type;

	cal_state_type                         state_ff;
	logic [adc_trim_pkg::CAL_CNT_W-1:0]    count_ff;
	logic                                  done_ff;

	localparam logic [adc_trim_pkg::CAL_CNT_W-1:0] LAST =
		adc_trim_pkg::CAL_CNT_W'(adc_trim_pkg::CAL_CYCLES - 1);

	// a start during a run restarts the count
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_ff <= CAL_IDLE;
			count_ff <= '0;
		end else if (start) begin
			state_ff <= CAL_RUN;
			count_ff <= '0;
		end else begin
			unique case (state_ff)
				CAL_IDLE: begin
					count_ff <= '0;
				end
				CAL_RUN: begin
					if (count_ff == LAST) begin
						state_ff <= CAL_IDLE;
					end
					count_ff <= count_ff + 1'b1;
				end
				default: begin
					state_ff <= CAL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
		end else if (start) begin
			done_ff <= 1'b0;
		end else if (state_ff == CAL_RUN && count_ff == LAST) begin
			done_ff <= 1'b1;
		end
	end

	assign busy = (state_ff == CAL_RUN);
	assign done = done_ff;

endmodule : synth_cal_timer
`default_nettype wire

// ---- offset_trim_path.sv ----
/*
 offset_trim_path: adds the global offset, scaled to the output mode, to one
 channel sample and saturates.
 assumes: sample_in is signed, left aligned to 18 bits, with 3 extra fraction bits.
*/
`timescale 1ns/10ps
`default_nettype none
module offset_trim_path (
	input  wire logic                                        sys_clk,
	input  wire logic                                        rst_n,
	input  wire logic signed [adc_trim_pkg::DATA_W+adc_trim_pkg::FRAC_W-1:0] sample_in,
	input  wire logic        [15:0]                          offset,
	input  wire adc_trim_pkg::res_mode_type                  mode,
	output logic signed      [adc_trim_pkg::DATA_W+adc_trim_pkg::FRAC_W-1:0] sample_out
);

	localparam int W  = adc_trim_pkg::DATA_W + adc_trim_pkg::FRAC_W;
	// an 18-bit LSb sits FRAC_W bits up; each coarser mode doubles the step
	localparam int SH = adc_trim_pkg::FRAC_W;

	logic signed [W+1:0] scaled;
	logic signed [W+1:0] sum;
	logic signed [W-1:0] out_ff;

	// step: 1/8 LSb at 12 bit up to 1 LSb at 18 bit; two guard bits for the sum
	always_comb begin
		unique case (mode)
			adc_trim_pkg::RES_12: scaled = (W+2)'($signed(offset)) <<< (SH + 3);
			adc_trim_pkg::RES_14: scaled = (W+2)'($signed(offset)) <<< (SH + 2);
			adc_trim_pkg::RES_16: scaled = (W+2)'($signed(offset)) <<< (SH + 1);
			adc_trim_pkg::RES_18: scaled = (W+2)'($signed(offset)) <<< SH;
		endcase
		sum = (W+2)'(sample_in) + scaled;
	end

	// saturate, so a large trim cannot wrap full scale
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			out_ff <= '0;
		end else if (sum[W+1:W-1] != {3{sum[W+1]}}) begin
			out_ff <= sum[W+1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
		end else begin
			out_ff <= sum[W-1:0];
		end
	end

	assign sample_out = out_ff;

endmodule : offset_trim_path
`default_nettype wire

// ---- adc_trim_chk.sv ----
/*
 adc_trim_chk: port assertions for the output trim and synthesizer register bank.
 assumes: bound to adc_output_trim_pll_regs, one clock, sync active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_trim_chk (
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	input  wire logic                       hsel,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic                       hready,
	input  wire logic [31:0]                hrdata,
	input  wire logic                       hreadyout,
	input  wire logic [1:0]                 hresp,
	input  wire adc_trim_pkg::res_mode_type resMode,
	input  wire logic                       decimationOn,
	input  wire logic                       pllSelected,
	input  wire logic                       pllEnabled,
	input  wire logic [17:0]                dataOut,
	input  wire logic [1:0]                 wckOvrOut,
	input  wire logic                       wckOvrOutEn,
	input  wire logic [15:0]                patternOut,
	input  wire logic                       pllClkToCore,
	input  wire logic [3:0]                 outclkVcoDelay,
	input  wire logic                       calStart
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_okay; hreadyout && hresp == adc_trim_pkg::HRESP_OKAY && hrdata[31:8] == 24'h0; endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
	property p_cal; calStart |-> $past(hsel && hwrite && htrans[1] && hready, 2); endproperty
	a_cal: assert property (p_cal) else $error("calibration start without a write");
	property p_pll; pllClkToCore |-> $past(pllSelected && pllEnabled); endproperty
	a_pll: assert property (p_pll) else $error("pll clock passed while not selected");
	property p_dly; outclkVcoDelay != 4'h0 |-> $past(pllSelected && pllEnabled && !decimationOn); endproperty
	a_dly: assert property (p_dly) else $error("output clock delay while not allowed");
	property p_code; outclkVcoDelay inside {[4'h0:4'h5], 4'hE, 4'hF}; endproperty
	a_code: assert property (p_code) else $error("delay cycles outside the code table");
	property p_wck; !wckOvrOutEn [*2] |-> wckOvrOut == 2'h0; endproperty
	a_wck: assert property (p_wck) else $error("word clock pair driven while disabled");
	property p_pat12; resMode == adc_trim_pkg::RES_12 [*2] |-> patternOut[3:0] == 4'h0; endproperty
	a_pat12: assert property (p_pat12) else $error("unused pattern bits at 12 bit");
	property p_pat14; resMode == adc_trim_pkg::RES_14 [*2] |-> patternOut[1:0] == 2'h0; endproperty
	a_pat14: assert property (p_pat14) else $error("unused pattern bits at 14 bit");
	property p_lsb; !decimationOn [*3] |-> dataOut[1:0] == 2'h0; endproperty
	a_lsb: assert property (p_lsb) else $error("extra low bits without decimation");
	property p_rst; rst_n && !$past(rst_n) |-> !pllClkToCore && wckOvrOutEn; endproperty
	a_rst: assert property (p_rst) else $error("wrong output levels after reset");
endmodule : adc_trim_chk
`default_nettype wire

// ---- ahb_host_model.sv ----
/*
 ahb_host_model: AHB-Lite master standing in for host software.
 assumes: single slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/10ps
`default_nettype none
module ahb_host_model (
	input  wire logic        sys_clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// gap gives slow hosts; byte address is four times the index
	task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d, input int gap,
		output logic [7:0] q);
		repeat (gap + 1) @(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {22'h0, i, 2'h0};
		htrans <= adc_trim_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge sys_clk); while (hready !== 1'b1);
		q = hrdata[7:0];
		// released data bus never keeps the last word
		hwdata <= ~hwdata;
	endtask : xfer
endmodule : ahb_host_model
`default_nettype wire

// ---- adc_output_trim_pll_regs_test.sv ----
/*
 adc_output_trim_pll_regs_test: self-checking bench for the trim register bank.
 assumes: ahb_host_model as bus master, checker bound below.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_output_trim_pll_regs_test;
	logic                       sys_clk, rst_n, hsel, hwrite, hreadyout;
	logic [31:0]                haddr, hwdata, hrdata, seed;
	logic [1:0]                 htrans, hresp, extraLsbOut, wckOvrOut;
	logic [2:0]                 hsize;
	logic signed [20:0]         sampleIn;
	adc_trim_pkg::res_mode_type resMode;
	logic                       decimationOn, pllSelected, pllEnabled, lvdsMode, wordClock, overRange;
	logic [17:0]                dataOut;
	logic                       wckOvrOutEn, pllClkToCore, calStart;
	logic [15:0]                patternOut, o;
	logic [3:0]                 outclkVcoDelay;
	logic [7:0]                 q, v, c;
	logic [20:0]                e;
	int                         numErrors, checks, calPulses, n, k;
	localparam logic [7:0] IDX [8] = '{8'h66, 8'h67, 8'h68, 8'h6B, 8'h6D, 8'h74, 8'h75, 8'h70};
	localparam logic [7:0] RST [8] = '{8'h00, 8'h00, 8'h24, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] MSK [8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h00};

	adc_output_trim_pll_regs dut (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sampleIn, .resMode,
		.decimationOn, .pllSelected, .pllEnabled, .lvdsMode, .wordClock, .overRange, .dataOut,
		.extraLsbOut, .wckOvrOut, .wckOvrOutEn, .patternOut, .pllClkToCore, .outclkVcoDelay,
		.calStart);
	ahb_host_model host (.sys_clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (calStart === 1'b1) calPulses <= calPulses + 1;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// offset step in 1/8 units of the 18-bit grid: 8x at 18 bit down to 64x at 12 bit
	function automatic logic [20:0] trim(input logic [20:0] s, input logic [15:0] f, input int m);
		logic signed [24:0] t;
		t = $signed({{4{s[20]}}, s}) + ($signed({{9{f[15]}}, f}) <<< (6 - m));
		if (t > 25'sh00FFFFF) t = 25'sh00FFFFF;
		if (t < -25'sh0100000) t = -25'sh0100000;
		return t[20:0];
	endfunction : trim
	function automatic logic [3:0] dly(input logic [2:0] d);
		return (d == 3'h6) ? 4'hE : (d == 3'h7) ? 4'hF : {1'b0, d};
	endfunction : dly
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
		checks++;
		if (s !== x) begin
			numErrors++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
		seed = lfsr(seed);
		host.xfer(w, i, d, int'(seed[1:0]), q);
	endtask : acc
	task automatic give_verdict();
		if (numErrors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (20000) @(posedge sys_clk);
		numErrors++;
		give_verdict();
	end

	initial begin
		{rst_n, decimationOn, pllSelected, pllEnabled, lvdsMode, wordClock, overRange} = 7'h0;
		sampleIn = 21'h0;
		resMode = adc_trim_pkg::RES_12;
		seed = 32'h9D1F;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		chk("pllClkToCore", 1'b0, pllClkToCore);
		chk("wckOvrOutEn", 1'b1, wckOvrOutEn);
		for (k = 0; k < 8; k++) begin
			acc(1'b0, IDX[k], 8'h00);
			chk("reset value", RST[k], q);
			seed = lfsr(seed);
			v = seed[7:0];
			acc(1'b1, IDX[k], v);
			acc(1'b0, IDX[k], 8'h00);
			chk("read back", v & MSK[k], q);
		end
		// calibration: toggle both ways, a repeated value starts nothing
		acc(1'b0, 8'h6B, 8'h00);
		c = q;
		n = calPulses;
		acc(1'b1, 8'h6B, c ^ 8'h04);
		acc(1'b1, 8'h6B, c ^ 8'h04);
		acc(1'b0, 8'hD1, 8'h00);
		chk("status busy", 8'h02, q);
		repeat (adc_trim_pkg::CAL_CYCLES + 10) @(posedge sys_clk);
		acc(1'b0, 8'hD1, 8'h00);
		chk("status done", 8'h01, q);
		acc(1'b1, 8'h6B, c);
		repeat (2) @(posedge sys_clk);
		chk("start count", 2, calPulses - n);
		for (k = 0; k < 32; k++) begin
			seed = lfsr(seed);
			v = seed[7:0];
			pllSelected <= k[3];
			pllEnabled <= k[4];
			decimationOn <= v[0];
			acc(1'b1, 8'h6D, {2'h0, v[1], 1'b0, k[2:0], 1'b0});
			repeat (3) @(posedge sys_clk);
			chk("pllClkToCore", v[1] & k[3] & k[4], pllClkToCore);
			chk("outclkVcoDelay", (k[4:3] == 2'h3 && !v[0]) ? dly(k[2:0]) : 4'h0,
				outclkVcoDelay);
		end
		for (k = 0; k < 16; k++) begin
			wordClock <= k[0];
			overRange <= k[1];
			acc(1'b1, 8'h68, {4'h0, k[3], k[2], 2'h0});
			repeat (3) @(posedge sys_clk);
			chk("wckOvrOutEn", k[2], wckOvrOutEn);
			chk("wckOvrOut", ({k[0], k[1]} ^ {2{k[3]}}) & {2{k[2]}}, wckOvrOut);
		end
		for (k = 0; k < 32; k++) begin
			seed = lfsr(seed);
			o = (k < 2) ? (k[0] ? 16'h8000 : 16'h7FFF) : seed[15:0];
			acc(1'b1, 8'h66, o[7:0]);
			acc(1'b1, 8'h67, o[15:8]);
			acc(1'b1, 8'h68, {5'h1, k[4], k[3], k[4]});
			seed = lfsr(seed);
			sampleIn <= seed[20:0];
			resMode <= adc_trim_pkg::res_mode_type'(k[1:0]);
			decimationOn <= k[2];
			lvdsMode <= seed[21];
			repeat (4) @(posedge sys_clk);
			e = trim(sampleIn, o, k[1:0]);
			n = 12 + 2 * k[1:0];
			if (n == 18 && k[3:2] != 2'h3) n = 16;
			chk("dataOut", {14'h0, e[20:3]} >> (18 - n), {14'h0, dataOut} >> (18 - n));
			if (k[3:1] == 3'h7) begin
				chk("dataOut low", e[4:3], dataOut[1:0]);
				chk("extraLsbOut", e[4:3] ^ {2{k[4] & lvdsMode}}, extraLsbOut);
			end
		end
		// ones in the unused bits on purpose, then a clean pattern
		acc(1'b1, 8'h74, 8'hFF);
		acc(1'b1, 8'h75, 8'hFF);
		for (k = 0; k < 4; k++) begin
			resMode <= adc_trim_pkg::res_mode_type'(k[1:0]);
			repeat (3) @(posedge sys_clk);
			chk("patternOut", (k > 1) ? 16'hFFFF : 16'(16'hFFFF << (4 - 2 * k)), patternOut);
		end
		acc(1'b1, 8'h74, 8'hA0);
		repeat (3) @(posedge sys_clk);
		chk("patternOut", 16'hFFA0, patternOut);
		give_verdict();
	end
endmodule : adc_output_trim_pll_regs_test

bind adc_output_trim_pll_regs adc_trim_chk chk (.sys_clk, .rst_n, .hsel, .htrans, .hwrite,
	.hready, .hrdata, .hreadyout, .hresp, .resMode, .decimationOn, .pllSelected, .pllEnabled,
	.dataOut, .wckOvrOut, .wckOvrOutEn, .patternOut, .pllClkToCore, .outclkVcoDelay, .calStart);
`default_nettype wire
